/* File: bench/testbench.sv */
// Self-checking bench for the identity words and user OTP bank
`timescale 1ns/10ps
`default_nettype none
`include "pio_cfg.svh"
module testbench;
    import pio_pkg::*;
    // Arbitrary identity values for this run
    localparam logic [23:0] REV_V = 24'h00A5C3;
    localparam logic [7:0] FAM_V = 8'h3C;
    localparam logic [7:0] VAR_V = 8'h11;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] d;
    logic [1:0] r;

    pio_top #(.REV_VALUE(REV_V), .FAMILY_VALUE(FAM_V), .VARIANT_VALUE(VAR_V)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    // Clock of 100 ns period
    always #50 aclk = ~aclk;

    // Watchdog against a hung handshake
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %s resp %h exp %h", $time, m, got, exp);
        end
    endtask

    // Write cycle: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ga, gw, sa, sw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ga && gw)) begin
            @(negedge aclk);
            sa = awready;
            sw = wready;
            @(posedge aclk);
            if (sa && !ga) begin
                awvalid <= 1'b0;
                ga = 1'b1;
            end
            if (sw && !gw) begin
                wvalid <= 1'b0;
                gw = 1'b1;
            end
        end
        sa = 1'b0;
        while (!sa) begin
            @(negedge aclk);
            sa = bvalid;
            rs = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
    endtask

    // Read cycle: address held until taken, data taken with rvalid
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic s;
        s = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!s) begin
            @(negedge aclk);
            s = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        s = 1'b0;
        while (!s) begin
            @(negedge aclk);
            s = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask

    // Stage a word, issue a command and poll the status bits
    task automatic do_cmd(input logic [5:0] i, input logic [47:0] v, input logic [31:0] op,
                          output logic [31:0] st);
        logic [1:0] rs;
        wr(`PIO_OFS_STAT, 32'h0000_0007, rs);
        wr(`PIO_OFS_DLO, v[31:0], rs);
        wr(`PIO_OFS_DHI, {16'h0000, v[47:32]}, rs);
        wr(`PIO_OFS_CMD, op | {18'h0, i, 8'h00}, rs);
        st = 32'h0;
        for (int n = 0; n < 10 && st[2:0] == 3'h0; n++) begin
            rd(`PIO_OFS_STAT, st, rs);
        end
    endtask

    // Read back one OTP word and compare both halves
    task automatic otp_chk(input logic [5:0] i, input logic [47:0] v, input logic pgm);
        logic [11:0] a;
        logic [31:0] g;
        logic [1:0] rs;
        a = 12'h200 + {3'h0, i, 3'h0};
        rd(a, g, rs);
        chk_data(g, v[31:0], "otp low");
        rd(a + 12'h004, g, rs);
        chk_data(g, {pgm, 15'h0000, v[47:32]}, "otp high");
    endtask

    task automatic t_ident();
        rd(`PIO_OFS_REV, d, r);
        chk_data(d, {8'h00, REV_V}, "revision");
        rd(`PIO_OFS_IDENT, d, r);
        chk_data(d, {8'h00, 8'hFF, FAM_V, VAR_V}, "identity");
        wr(`PIO_OFS_REV, 32'hFFFF_FFFF, r);
        chk_resp(r, `PIO_RESP_OKAY, "rev write");
        wr(`PIO_OFS_IDENT, 32'h0000_0000, r);
        rd(`PIO_OFS_REV, d, r);
        chk_data(d, {8'h00, REV_V}, "revision kept");
        rd(`PIO_OFS_IDENT, d, r);
        chk_data(d, {8'h00, 8'hFF, FAM_V, VAR_V}, "identity kept");
    endtask

    task automatic t_program();
        otp_chk(6'd0, 48'h0, 1'b0);
        do_cmd(6'd0, 48'hA1B2_C3D4_E5F6, 32'h1, d);
        chk_data({29'h0, d[2:0]}, 32'h1, "prog done");
        otp_chk(6'd0, 48'hA1B2_C3D4_E5F6, 1'b1);
        do_cmd(6'd63, 48'h0123_4567_89AB, 32'h1, d);
        chk_data({29'h0, d[2:0]}, 32'h1, "prog last");
        otp_chk(6'd63, 48'h0123_4567_89AB, 1'b1);
    endtask

    task automatic t_twice();
        do_cmd(6'd0, 48'hFFFF_FFFF_FFFF, 32'h1, d);
        chk_data({29'h0, d[2:0]}, 32'h2, "second prog refused");
        wr(12'h200, 32'h5555_5555, r);
        chk_resp(r, `PIO_RESP_OKAY, "direct otp write");
        otp_chk(6'd0, 48'hA1B2_C3D4_E5F6, 1'b1);
    endtask

    task automatic t_erase();
        do_cmd(6'd0, 48'h0, 32'h2, d);
        chk_data({29'h0, d[2:0]}, 32'h4, "erase seen");
        otp_chk(6'd0, 48'hA1B2_C3D4_E5F6, 1'b1);
        otp_chk(6'd63, 48'h0123_4567_89AB, 1'b1);
        otp_chk(6'd5, 48'h0, 1'b0);
    endtask

    task automatic t_unmapped();
        rd(12'h100, d, r);
        chk_resp(r, `PIO_RESP_SLVERR, "unmapped read");
        chk_data(d, 32'h0, "unmapped data");
        rd(12'h002, d, r);
        chk_resp(r, `PIO_RESP_SLVERR, "unaligned read");
        wr(12'h100, 32'h1234_5678, r);
        chk_resp(r, `PIO_RESP_SLVERR, "unmapped write");
        rd(`PIO_OFS_CMD, d, r);
        chk_data(d, 32'h0, "command reads zero");
        chk_resp(r, `PIO_RESP_OKAY, "command read");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_ident();
        t_program();
        t_twice();
        t_erase();
        t_unmapped();
        results();
    end
endmodule
`default_nettype wire

/* File: hw/pio_cfg.svh */
// Address map, field positions and reset values of the identity and OTP register bank
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
`define PIO_ADDR_W 12
`define PIO_OFS_REV 12'h000
`define PIO_OFS_IDENT 12'h004
`define PIO_OFS_CMD 12'h008
`define PIO_OFS_STAT 12'h00C
`define PIO_OFS_DLO 12'h010
`define PIO_OFS_DHI 12'h014
`define PIO_OTP_WIN_TAG 3'h1
`define PIO_OTP_WORDS 64
`define PIO_OTP_WIDTH 48
`define PIO_OTP_PADDR_FIRST 24'h801700
`define PIO_OTP_PADDR_LAST 24'h8017FE
`define PIO_CMD_PROG_BIT 0
`define PIO_CMD_ERASE_BIT 1
`define PIO_CMD_IDX_LSB 8
`define PIO_STAT_DONE_BIT 0
`define PIO_STAT_REFUSED_BIT 1
`define PIO_STAT_ERASE_BIT 2
`define PIO_IDENT_PAD 8'hFF
`define PIO_REV_RESET 24'h000001
`define PIO_FAMILY_RESET 8'h5A
`define PIO_VARIANT_RESET 8'h03
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2
`endif

/* File: hw/pio_otp_array.sv */
// Write-once OTP word array that no erase can touch
`timescale 1ns/10ps
`default_nettype none
`include "pio_cfg.svh"
module pio_otp_array #(
    parameter int WORDS = `PIO_OTP_WORDS,
    parameter int WIDTH = `PIO_OTP_WIDTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pio_pkg::pio_otp_req_type req,
    input wire logic [5:0] rd_idx,
    output logic [WIDTH-1:0] rd_word,
    output logic rd_written,
    output pio_pkg::pio_otp_res_type res
);
    import pio_pkg::*;

    typedef struct packed {
        logic [WORDS-1:0][WIDTH-1:0] mem;
        logic [WORDS-1:0] written;
        pio_otp_res_type res;
    } pio_arr_state_type;

    pio_arr_state_type st_ff;
    pio_arr_state_type nxt_st;

    // One program per word; erase leaves the array alone and only raises erase_seen
    always_comb begin
        nxt_st = st_ff;
        nxt_st.res = '0;
        if (req.prog) begin
            if (st_ff.written[req.idx]) begin
                nxt_st.res.refused = 1'b1;
            end else begin
                nxt_st.mem[req.idx] = req.data;
                nxt_st.written[req.idx] = 1'b1;
                nxt_st.res.done = 1'b1;
            end
        end
        if (req.erase) begin
            nxt_st.res.erase_seen = 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read port, straight from the array
    assign rd_word = st_ff.mem[rd_idx];
    assign rd_written = st_ff.written[rd_idx];
    assign res = st_ff.res;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Refused program leaves the whole array as it was
    property p_second_write_blocked;
        req.prog && st_ff.written[req.idx]
            |=> st_ff.mem == $past(st_ff.mem) && res.refused;
    endproperty
    a_second_write_blocked: assert property (p_second_write_blocked)
        else $error("programmed OTP word changed");

    property p_first_write_stores;
        req.prog && !st_ff.written[req.idx] && !req.erase
            |=> st_ff.mem[$past(req.idx)] == $past(req.data)
                && st_ff.written[$past(req.idx)] && res.done;
    endproperty
    a_first_write_stores: assert property (p_first_write_stores)
        else $error("first OTP program not stored");

    property p_erase_ignored;
        (req.erase && !req.prog) |=> $stable(st_ff.mem) && $stable(st_ff.written);
    endproperty
    a_erase_ignored: assert property (p_erase_ignored)
        else $error("erase altered OTP contents");
endmodule
`default_nettype wire

/* File: hw/pio_pkg.sv */
// Types shared by the identity and OTP register bank
`default_nettype none
`include "pio_cfg.svh"
package pio_pkg;
    typedef enum logic [2:0] {
        PIO_REG_REV,
        PIO_REG_IDENT,
        PIO_REG_CMD,
        PIO_REG_STAT,
        PIO_REG_DLO,
        PIO_REG_DHI,
        PIO_REG_OTP,
        PIO_REG_NONE
    } pio_region_type;

    // Request from the register bank to the OTP array
    typedef struct packed {
        logic prog;
        logic erase;
        logic [5:0] idx;
        logic [`PIO_OTP_WIDTH-1:0] data;
    } pio_otp_req_type;

    // Result pulses from the OTP array
    typedef struct packed {
        logic done;
        logic refused;
        logic erase_seen;
    } pio_otp_res_type;

    // Whole state of the register bank
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic [`PIO_ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [`PIO_ADDR_W-1:0] rd_addr;
        logic [31:0] stage_lo;
        logic [15:0] stage_hi;
        logic [2:0] sticky;
        pio_otp_req_type req;
    } pio_state_type;
endpackage
`default_nettype wire

/* File: hw/pio_top.sv */
// Identity words and user OTP bank behind an AXI4-Lite slave
// Function
// - Both identity registers read-only, writes ignored.
// - Revision word returns 24-bit value, bits 23:0.
// - Identity bits 15:8 hold fixed family code.
// - Identity bits 7:0 hold variant code.
// - Sixty-four OTP double words, readable as data.
// - Each 48-bit OTP word programs only once.
// - No erase command alters OTP contents.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pio_cfg.svh"
module pio_top #(
    parameter logic [23:0] REV_VALUE = `PIO_REV_RESET, // Arbitrary value
    parameter logic [7:0] FAMILY_VALUE = `PIO_FAMILY_RESET, // Arbitrary value
    parameter logic [7:0] VARIANT_VALUE = `PIO_VARIANT_RESET // Arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`PIO_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PIO_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pio_pkg::*;

    pio_state_type st_ff;
    pio_state_type nxt_st;
    logic [`PIO_OTP_WIDTH-1:0] otp_word;
    logic otp_written;
    pio_otp_res_type otp_res;

    // Address decode shared by read and write paths
    function automatic pio_region_type decode(input logic [`PIO_ADDR_W-1:0] a);
        pio_region_type r;
        r = PIO_REG_NONE;
        if (a[11:9] == `PIO_OTP_WIN_TAG && a[1:0] == 2'h0) begin
            r = PIO_REG_OTP;
        end else begin
            case (a)
                `PIO_OFS_REV: r = PIO_REG_REV;
                `PIO_OFS_IDENT: r = PIO_REG_IDENT;
                `PIO_OFS_CMD: r = PIO_REG_CMD;
                `PIO_OFS_STAT: r = PIO_REG_STAT;
                `PIO_OFS_DLO: r = PIO_REG_DLO;
                `PIO_OFS_DHI: r = PIO_REG_DHI;
                default: r = PIO_REG_NONE;
            endcase
        end
        return r;
    endfunction

    // Byte-lane merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[8*b +: 8] = d[8*b +: 8];
            end
        end
        return m;
    endfunction

    // OTP storage
    pio_otp_array #(
        .WORDS(`PIO_OTP_WORDS),
        .WIDTH(`PIO_OTP_WIDTH)
    ) u_otp (
        .aclk(aclk),
        .aresetn(aresetn),
        .req(st_ff.req),
        .rd_idx(s_axi_araddr[8:3]),
        .rd_word(otp_word),
        .rd_written(otp_written),
        .res(otp_res)
    );

    // Bus handshakes, register writes and reads
    always_comb begin
        logic [31:0] wv;
        logic [31:0] hv;
        logic [2:0] set_bits;
        pio_region_type wr_reg;
        pio_region_type rd_reg;
        wv = '0;
        hv = '0;
        set_bits = {otp_res.erase_seen, otp_res.refused, otp_res.done};
        wr_reg = decode(st_ff.aw_addr);
        rd_reg = decode(s_axi_araddr);
        nxt_st = st_ff;
        nxt_st.req = '0;
        // Address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // Perform write once both halves are in and no response waits
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `PIO_RESP_OKAY;
            wv = merge(32'h0000_0000, st_ff.w_data, st_ff.w_strb);
            case (wr_reg)
                PIO_REG_REV, PIO_REG_IDENT, PIO_REG_OTP: begin
                    nxt_st.bresp = `PIO_RESP_OKAY;
                end
                PIO_REG_CMD: begin
                    nxt_st.req.prog = wv[`PIO_CMD_PROG_BIT];
                    nxt_st.req.erase = wv[`PIO_CMD_ERASE_BIT];
                    nxt_st.req.idx = wv[`PIO_CMD_IDX_LSB +: 6];
                    nxt_st.req.data = {st_ff.stage_hi, st_ff.stage_lo};
                end
                PIO_REG_STAT: begin
                    nxt_st.sticky = st_ff.sticky & ~wv[2:0];
                end
                PIO_REG_DLO: begin
                    nxt_st.stage_lo = merge(st_ff.stage_lo, st_ff.w_data, st_ff.w_strb);
                end
                PIO_REG_DHI: begin
                    // Only the low half lane holds staged bits
                    hv = merge({16'h0000, st_ff.stage_hi}, st_ff.w_data, st_ff.w_strb);
                    nxt_st.stage_hi = hv[15:0];
                end
                default: begin
                    nxt_st.bresp = `PIO_RESP_SLVERR;
                end
            endcase
        end
        // Hardware set wins over software clear
        nxt_st.sticky = nxt_st.sticky | set_bits;
        nxt_st.awready = !nxt_st.aw_got;
        nxt_st.wready = !nxt_st.w_got;
        // Read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rd_addr = s_axi_araddr;
            nxt_st.rresp = `PIO_RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            case (rd_reg)
                PIO_REG_REV: nxt_st.rdata = {8'h00, REV_VALUE};
                PIO_REG_IDENT: begin
                    nxt_st.rdata = {8'h00, `PIO_IDENT_PAD, FAMILY_VALUE, VARIANT_VALUE};
                end
                PIO_REG_CMD: nxt_st.rdata = 32'h0000_0000;
                PIO_REG_STAT: nxt_st.rdata = {29'h0, st_ff.sticky};
                PIO_REG_DLO: nxt_st.rdata = st_ff.stage_lo;
                PIO_REG_DHI: nxt_st.rdata = {16'h0000, st_ff.stage_hi};
                PIO_REG_OTP: begin
                    if (s_axi_araddr[2]) begin
                        nxt_st.rdata = {otp_written, 15'h0000, otp_word[47:32]};
                    end else begin
                        nxt_st.rdata = otp_word[31:0];
                    end
                end
                default: nxt_st.rresp = `PIO_RESP_SLVERR;
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_ident;
        st_ff.aw_got && st_ff.w_got && !st_ff.bvalid &&
            (st_ff.aw_addr == `PIO_OFS_IDENT || st_ff.aw_addr == `PIO_OFS_REV);
    endsequence
    sequence s_ok_resp;
        s_axi_bvalid && s_axi_bresp == `PIO_RESP_OKAY;
    endsequence
    property p_id_write_ignored;
        s_wr_ident |=> s_ok_resp ##0 ($stable(st_ff.stage_lo) && !st_ff.req.prog);
    endproperty
    a_id_write_ignored: assert property (p_id_write_ignored)
        else $error("identity write not answered as ignored");

    property p_rev_value;
        s_axi_rvalid && st_ff.rd_addr == `PIO_OFS_REV |-> s_axi_rdata == {8'h00, REV_VALUE};
    endproperty
    a_rev_value: assert property (p_rev_value)
        else $error("revision word wrong");

    property p_family;
        s_axi_rvalid && st_ff.rd_addr == `PIO_OFS_IDENT |-> s_axi_rdata[15:8] == FAMILY_VALUE;
    endproperty
    a_family: assert property (p_family)
        else $error("family field wrong");

    property p_variant;
        s_axi_rvalid && st_ff.rd_addr == `PIO_OFS_IDENT |-> s_axi_rdata[7:0] == VARIANT_VALUE;
    endproperty
    a_variant: assert property (p_variant)
        else $error("variant field wrong");

    property p_pad_ones;
        s_axi_rvalid && st_ff.rd_addr == `PIO_OFS_IDENT |-> s_axi_rdata[23:16] == 8'hFF;
    endproperty
    a_pad_ones: assert property (p_pad_ones)
        else $error("identity bits 23:16 not ones");

    property p_otp_read;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:9] == `PIO_OTP_WIN_TAG &&
            s_axi_araddr[1:0] == 2'h0 && !s_axi_araddr[2])
            |=> s_axi_rvalid && s_axi_rresp == `PIO_RESP_OKAY
                && s_axi_rdata == $past(otp_word[31:0]);
    endproperty
    a_otp_read: assert property (p_otp_read)
        else $error("OTP read data or timing wrong");

    property p_prog_result;
        st_ff.req.prog |=> (otp_res.done ^ otp_res.refused) ##1
            st_ff.sticky[`PIO_STAT_DONE_BIT] || st_ff.sticky[`PIO_STAT_REFUSED_BIT];
    endproperty
    a_prog_result: assert property (p_prog_result)
        else $error("program result not reported");
endmodule
`default_nettype wire
